// File: wkin_pkg.sv
// Constants, encodings and carrier types for the wake input detection block.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package wkin_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Sizes and timing.
  localparam int WKIN_N_WAKE = 3;
  localparam int WKIN_N_ALT = 2;
  localparam int WKIN_CLK_HZ = 50_000_000;
  localparam int WKIN_FILT_SHORT_NS = 16000;
  localparam int WKIN_FILT_LONG_NS = 64000;
  localparam int WKIN_FILT_SHORT_CYC_I = (WKIN_FILT_SHORT_NS * (WKIN_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WKIN_FILT_LONG_CYC_I = (WKIN_FILT_LONG_NS * (WKIN_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [11:0] WKIN_FILT_SHORT_CYC = WKIN_FILT_SHORT_CYC_I[11:0];
  localparam logic [11:0] WKIN_FILT_LONG_CYC = WKIN_FILT_LONG_CYC_I[11:0];
  localparam int WKIN_TICK_CYCLES_DEFAULT = 50000;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] WKIN_ADDR_WAKE_ENABLE = 8'h00;
  localparam logic [7:0] WKIN_ADDR_BIAS = 8'h04;
  localparam logic [7:0] WKIN_ADDR_FILTER = 8'h08;
  localparam logic [7:0] WKIN_ADDR_SOURCE = 8'h0c;
  localparam logic [7:0] WKIN_ADDR_ALT_STATUS = 8'h10;
  localparam logic [7:0] WKIN_ADDR_LEVEL = 8'h14;
  localparam logic [7:0] WKIN_ADDR_SOURCE_MASK = 8'h18;
  localparam logic [7:0] WKIN_ADDR_ALT_MASK = 8'h1c;
  localparam logic [7:0] WKIN_ADDR_TIMER_A = 8'h20;
  localparam logic [7:0] WKIN_ADDR_TIMER_B = 8'h24;
  localparam logic [7:0] WKIN_ADDR_ALT_ENABLE = 8'h28;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values.
  localparam int WKIN_TIMER_ON_LSB = 0;
  localparam int WKIN_TIMER_PERIOD_LSB = 4;
  localparam logic [2:0] WKIN_WAKE_ENABLE_RST = 3'h0;
  localparam logic [5:0] WKIN_BIAS_RST = 6'h00;
  localparam logic [5:0] WKIN_FILTER_RST = 6'h00;
  localparam logic [2:0] WKIN_MASK_RST = 3'h0;
  localparam logic [7:0] WKIN_TIMER_RST = 8'h00;
  localparam logic [1:0] WKIN_ALT_RST = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Encodings.
  localparam logic [1:0] WKIN_BIAS_NONE = 2'h0;
  localparam logic [1:0] WKIN_BIAS_DOWN = 2'h1;
  localparam logic [1:0] WKIN_BIAS_UP = 2'h2;
  localparam logic [1:0] WKIN_BIAS_AUTO = 2'h3;
  localparam logic [1:0] WKIN_FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] WKIN_FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] WKIN_FLT_CYCLIC_A = 2'h2;
  localparam logic [1:0] WKIN_FLT_CYCLIC_B = 2'h3;

  typedef enum logic [1:0] {
    WKIN_MODE_NORMAL,
    WKIN_MODE_STOP,
    WKIN_MODE_SLEEP,
    WKIN_MODE_FAILSAFE
  } wkin_mode_t;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wkin_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wkin_apb_rsp_t;

  typedef struct packed {
    logic [2:0] wake;
    logic [1:0] alt;
  } wkin_pins_t;

  typedef struct packed {
    logic [2:0] pull_up;
    logic [2:0] pull_down;
  } wkin_bias_t;

endpackage : wkin_pkg

// File: wkin_top.sv
// Wake input detection: filters, cyclic sense timers, bias control and APB registers.
// Assumes pin levels are already synchronous to clk and the power mode comes from the mode controller.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module wkin_top #(
  parameter int TICK_CYCLES = wkin_pkg::WKIN_TICK_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire wkin_pkg::wkin_apb_req_t apb_req,
  output var wkin_pkg::wkin_apb_rsp_t apb_rsp,
  input wire wkin_pkg::wkin_pins_t pins,
  input wire wkin_pkg::wkin_mode_t sbc_mode,
  output var wkin_pkg::wkin_bias_t bias,
  output logic irq,
  output logic wake_req,
  output logic [1:0] timer_on
);
  import wkin_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    wkin_apb_rsp_t rsp;
    logic [2:0] wake_enable_control;
    logic [5:0] wake_bias_control;
    logic [5:0] wake_filter_control;
    logic [2:0] wake_source_status;
    logic [1:0] alt_wake_status;
    logic [2:0] wake_level_status;
    logic [2:0] source_mask;
    logic [1:0] alt_mask;
    logic [7:0] cyclic_timer_a_control;
    logic [7:0] cyclic_timer_b_control;
    logic [1:0] alt_enable;
    logic [2:0][11:0] filt_cnt;
    logic [2:0] stable;
    logic [2:0] sample;
    logic [1:0][11:0] alt_cnt;
    logic [1:0] alt_stable;
    logic [15:0] tick_cnt;
    logic [1:0][3:0] timer_cnt;
    logic [1:0] timer_on;
    wkin_bias_t bias;
    logic irq;
    logic wake_req;
  } wkin_state_t;

  wkin_state_t st;
  wkin_state_t next_st;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic [2:0] src_set;
    logic [1:0] alt_set;
    logic [2:0] src_clr;
    logic [1:0] alt_clr;
    logic [1:0] window_end;
    logic tick;
    logic active_mode;
    logic [1:0] flt;
    logic [1:0] bsel;
    logic [11:0] limit;
    logic win;
    logic wend;
    logic [3:0] per;
    logic [3:0] ontime;
    logic [7:0] tctl;
    logic wr;
    logic [31:0] rdata;
    logic rerr;
    next_st = st;
    src_set = 3'h0;
    alt_set = 2'h0;
    src_clr = 3'h0;
    alt_clr = 2'h0;
    window_end = 2'h0;
    flt = 2'h0;
    bsel = 2'h0;
    limit = 12'h000;
    win = 1'b0;
    wend = 1'b0;
    per = 4'h0;
    ontime = 4'h0;
    tctl = 8'h00;
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    tick = 1'b0;
    wr = 1'b0;
    active_mode = (sbc_mode == WKIN_MODE_NORMAL) || (sbc_mode == WKIN_MODE_STOP);

    // Cyclic sense timers share one prescaler; a zero period stops a timer.
    tick = (st.tick_cnt == TICK_LAST);
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    for (int t = 0; t < 2; t++) begin
      tctl = (t == 0) ? st.cyclic_timer_a_control : st.cyclic_timer_b_control;
      per = tctl[WKIN_TIMER_PERIOD_LSB +: 4];
      ontime = tctl[WKIN_TIMER_ON_LSB +: 4];
      if (per == 4'h0) begin
        next_st.timer_cnt[t] = 4'h0;
      end else if (tick) begin
        next_st.timer_cnt[t] = (st.timer_cnt[t] >= per - 4'h1) ? 4'h0 : st.timer_cnt[t] + 4'h1;
      end
      next_st.timer_on[t] = (per != 4'h0) && (next_st.timer_cnt[t] < ontime);
      window_end[t] = st.timer_on[t] && !next_st.timer_on[t];
    end

    // Main wake inputs.
    for (int i = 0; i < WKIN_N_WAKE; i++) begin
      flt = st.wake_filter_control[2*i +: 2];
      limit = (flt == WKIN_FLT_STATIC_LONG) ? WKIN_FILT_LONG_CYC : WKIN_FILT_SHORT_CYC;
      win = flt[1] ? st.timer_on[flt[0]] : 1'b1;
      wend = flt[1] && window_end[flt[0]];
      if (win && (pins.wake[i] != st.stable[i])) begin
        if (st.filt_cnt[i] == limit - 12'h001) begin
          next_st.stable[i] = pins.wake[i];
          next_st.filt_cnt[i] = 12'h000;
          if (!flt[1]) begin
            src_set[i] = st.wake_enable_control[i];
          end
        end else begin
          next_st.filt_cnt[i] = st.filt_cnt[i] + 12'h001;
        end
      end else begin
        next_st.filt_cnt[i] = 12'h000;
      end
      if (wend) begin
        next_st.sample[i] = st.stable[i];
        if (st.stable[i] != st.sample[i]) begin
          src_set[i] = st.wake_enable_control[i];
        end
      end
      if (active_mode) begin
        next_st.wake_level_status[i] = flt[1] ? next_st.sample[i] : next_st.stable[i];
      end
      bsel = st.wake_bias_control[2*i +: 2];
      case (bsel)
        WKIN_BIAS_NONE: begin
          next_st.bias.pull_up[i] = 1'b0;
          next_st.bias.pull_down[i] = 1'b0;
        end
        WKIN_BIAS_DOWN: begin
          next_st.bias.pull_up[i] = 1'b0;
          next_st.bias.pull_down[i] = 1'b1;
        end
        WKIN_BIAS_UP: begin
          next_st.bias.pull_up[i] = 1'b1;
          next_st.bias.pull_down[i] = 1'b0;
        end
        default: begin
          next_st.bias.pull_up[i] = next_st.stable[i];
          next_st.bias.pull_down[i] = !next_st.stable[i];
        end
      endcase
    end

    // Alternate output pins used as wake inputs: always static, short filter.
    for (int j = 0; j < WKIN_N_ALT; j++) begin
      if (st.alt_enable[j] && (pins.alt[j] != st.alt_stable[j])) begin
        if (st.alt_cnt[j] == WKIN_FILT_SHORT_CYC - 12'h001) begin
          next_st.alt_stable[j] = pins.alt[j];
          next_st.alt_cnt[j] = 12'h000;
          alt_set[j] = 1'b1;
        end else begin
          next_st.alt_cnt[j] = st.alt_cnt[j] + 12'h001;
        end
      end else begin
        next_st.alt_cnt[j] = 12'h000;
        if (!st.alt_enable[j]) begin
          next_st.alt_stable[j] = pins.alt[j];
        end
      end
    end

    // APB slave: read data is prepared one cycle ahead, a write lands on the pready edge.
    case (apb_req.paddr)
      WKIN_ADDR_WAKE_ENABLE: rdata = {29'h0, st.wake_enable_control};
      WKIN_ADDR_BIAS: rdata = {26'h0, st.wake_bias_control};
      WKIN_ADDR_FILTER: rdata = {26'h0, st.wake_filter_control};
      WKIN_ADDR_SOURCE: rdata = {29'h0, st.wake_source_status};
      WKIN_ADDR_ALT_STATUS: rdata = {30'h0, st.alt_wake_status};
      WKIN_ADDR_LEVEL: rdata = {29'h0, st.wake_level_status};
      WKIN_ADDR_SOURCE_MASK: rdata = {29'h0, st.source_mask};
      WKIN_ADDR_ALT_MASK: rdata = {30'h0, st.alt_mask};
      WKIN_ADDR_TIMER_A: rdata = {24'h0, st.cyclic_timer_a_control};
      WKIN_ADDR_TIMER_B: rdata = {24'h0, st.cyclic_timer_b_control};
      WKIN_ADDR_ALT_ENABLE: rdata = {30'h0, st.alt_enable};
      default: rerr = 1'b1;
    endcase
    wr = apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite && !st.rsp.pslverr;
    if (apb_req.psel && apb_req.penable && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = rerr;
      next_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end else begin
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = 32'h0000_0000;
    end
    if (wr) begin
      case (apb_req.paddr)
        WKIN_ADDR_WAKE_ENABLE: next_st.wake_enable_control = apb_req.pwdata[2:0];
        WKIN_ADDR_BIAS: next_st.wake_bias_control = apb_req.pwdata[5:0];
        WKIN_ADDR_FILTER: next_st.wake_filter_control = apb_req.pwdata[5:0];
        WKIN_ADDR_SOURCE: src_clr = apb_req.pwdata[2:0];
        WKIN_ADDR_ALT_STATUS: alt_clr = apb_req.pwdata[1:0];
        WKIN_ADDR_SOURCE_MASK: next_st.source_mask = apb_req.pwdata[2:0];
        WKIN_ADDR_ALT_MASK: next_st.alt_mask = apb_req.pwdata[1:0];
        WKIN_ADDR_TIMER_A: next_st.cyclic_timer_a_control = apb_req.pwdata[7:0];
        WKIN_ADDR_TIMER_B: next_st.cyclic_timer_b_control = apb_req.pwdata[7:0];
        WKIN_ADDR_ALT_ENABLE: next_st.alt_enable = apb_req.pwdata[1:0];
        default: begin
        end
      endcase
    end

    // Sticky status, a new event wins over a clear in the same cycle.
    next_st.wake_source_status = (st.wake_source_status & ~src_clr) | src_set;
    next_st.alt_wake_status = (st.alt_wake_status & ~alt_clr) | alt_set;
    next_st.irq = |(next_st.wake_source_status & next_st.source_mask) ||
                  |(next_st.alt_wake_status & next_st.alt_mask);
    if (sbc_mode == WKIN_MODE_NORMAL) begin
      next_st.wake_req = 1'b0;
    end else if (!active_mode && ((src_set != 3'h0) || (alt_set != 2'h0))) begin
      next_st.wake_req = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.wake_enable_control <= WKIN_WAKE_ENABLE_RST;
      st.wake_bias_control <= WKIN_BIAS_RST;
      st.wake_filter_control <= WKIN_FILTER_RST;
      st.source_mask <= WKIN_MASK_RST;
      st.alt_mask <= WKIN_ALT_RST;
      st.cyclic_timer_a_control <= WKIN_TIMER_RST;
      st.cyclic_timer_b_control <= WKIN_TIMER_RST;
      st.alt_enable <= WKIN_ALT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign bias = st.bias;
  assign irq = st.irq;
  assign wake_req = st.wake_req;
  assign timer_on = st.timer_on;

endmodule : wkin_top

`default_nettype wire

// File: wkin_properties.sv
// Port-level checker for the wake input detection block.
// Bound to wkin_top; sees only its ports and shares one clock and reset.
`timescale 1ns/100ps
`default_nettype none
module wkin_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire wkin_pkg::wkin_apb_req_t apb_req,
  input wire wkin_pkg::wkin_apb_rsp_t apb_rsp,
  input wire wkin_pkg::wkin_pins_t pins,
  input wire wkin_pkg::wkin_mode_t sbc_mode,
  input wire wkin_pkg::wkin_bias_t bias,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic [1:0] timer_on
);
  import wkin_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // Cycles each pin has held its level, and whether a timer was ever written.
  logic [11:0] stab [5];
  logic [4:0] prev;
  logic tmr_set;
  logic fresh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 5'h00;
      tmr_set <= 1'b0;
      for (int i = 0; i < 5; i++) stab[i] <= 12'h000;
    end else begin
      prev <= pins;
      tmr_set <= tmr_set | (apb_rsp.pready & apb_req.pwrite &
        (apb_req.paddr == WKIN_ADDR_TIMER_A || apb_req.paddr == WKIN_ADDR_TIMER_B));
      for (int i = 0; i < 5; i++) stab[i] <= (pins[i] != prev[i]) ? 12'h000 : stab[i] + {11'h000, stab[i] != 12'hfff};
    end
  end
  // A filter may only accept a pin that has just held for a whole filter time.
  always_comb begin
    fresh = 1'b0;
    for (int i = 0; i < 5; i++) fresh = fresh | (stab[i] >= 12'h31b && stab[i] <= 12'hce4);
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_access;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence s_answer;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  a_apb_answer: assert property ($rose(apb_req.penable) ##0 s_access |=> s_answer)
    else $error("pready not a one-cycle answer after access");
  a_slverr_map: assert property (apb_rsp.pready |-> apb_rsp.pslverr ==
    (apb_req.paddr > WKIN_ADDR_ALT_ENABLE || apb_req.paddr[1:0] != 2'h0)) else $error("pslverr wrong for address");
  a_err_zero: assert property (apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("refused read returned data");
  a_bias_exclusive: assert property ((bias.pull_up & bias.pull_down) == 3'h0)
    else $error("pull-up and pull-down both on");
  a_irq_filter: assert property ($rose(irq) && !$past(apb_rsp.pready) && !$past(apb_rsp.pready, 2) &&
    !$past(apb_rsp.pready, 3) && timer_on == 2'h0 && $past(timer_on, 3) == 2'h0 |-> fresh)
    else $error("interrupt without a filtered pin change");
  a_wake_mode: assert property ($rose(wake_req) |-> $past(sbc_mode) inside {WKIN_MODE_SLEEP, WKIN_MODE_FAILSAFE})
    else $error("wake request outside sleep or fail-safe");
  a_wake_clear: assert property (sbc_mode == WKIN_MODE_NORMAL |=> !wake_req)
    else $error("wake request held in normal mode");
  a_timer_idle: assert property (!tmr_set |-> timer_on == 2'h0)
    else $error("timer window without a timer setting");
endmodule : wkin_checker
bind wkin_top wkin_checker #(.TICK_CYCLES(TICK_CYCLES)) wkin_checker_i (.clk(clk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pins(pins), .sbc_mode(sbc_mode), .bias(bias), .irq(irq), .wake_req(wake_req),
  .timer_on(timer_on));
`default_nettype wire

// File: wkin_switch_model.sv
// External switches and a cyclically powered sensor on the wake pins.
// An open pin follows its bias source, or wanders every cycle when none is on.
`timescale 1ns/100ps
`default_nettype none
module wkin_switch_model (
  input wire logic clk,
  input wire logic [4:0] sw_closed,
  input wire logic [4:0] sw_level,
  input wire logic cyc_supply,
  input wire logic high_side_out_one,
  input wire wkin_pkg::wkin_bias_t bias,
  output var wkin_pkg::wkin_pins_t pins
);
  import wkin_pkg::*;
  logic flip = 1'b0;
  logic [4:0] open_lvl;
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    open_lvl = {bias.pull_up | (~bias.pull_down & {3{flip}}), {2{flip}}};
    pins = (sw_closed & sw_level) | (~sw_closed & open_lvl);
    // An unpowered sensor on input three gives no valid level.
    if (cyc_supply && !high_side_out_one) pins.wake[2] = flip;
  end
endmodule : wkin_switch_model
`default_nettype wire

// File: tb_wake_input_detection.sv
// Self-checking bench: APB register tasks and pin stimulus through the switch model.
// Uses a short timer prescaler; filter times are the package's cycle counts.
`timescale 1ns/100ps
`default_nettype none
module tb_wake_input_detection;
  import wkin_pkg::*;
  localparam int TICKS = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wkin_apb_req_t req = '0;
  wkin_apb_rsp_t rsp;
  wkin_pins_t pins;
  wkin_mode_t mode = WKIN_MODE_NORMAL;
  wkin_bias_t bias;
  logic irq;
  logic wake_req;
  logic [1:0] timer_on;
  logic [4:0] sw_level = 5'h00;
  logic cyc_supply = 1'b0;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  wkin_top #(.TICK_CYCLES(TICKS)) wkin_top_i (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .pins(pins),
    .sbc_mode(mode), .bias(bias), .irq(irq), .wake_req(wake_req), .timer_on(timer_on));
  wkin_switch_model wkin_switch_model_i (.clk(clk), .sw_closed(5'h1f), .sw_level(sw_level), .cyc_supply(cyc_supply),
    .high_side_out_one(timer_on[1]), .bias(bias), .pins(pins));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Read data and error are taken at the edge that samples pready high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask : xfer
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic pinset(input logic [4:0] lv);
    @(posedge clk);
    sw_level <= lv;
  endtask : pinset
  task automatic wait_on(input logic lv);
    int n;
    for (n = 0; n < 3000 && timer_on[1] !== lv; n++) cyc(1);
    if (n == 3000) begin
      bad_count++;
      finish_test();
    end
  endtask : wait_on
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 'h2c; a += 4) rdc("reset_value", a[7:0], 32'h0);
    xfer(1'b1, WKIN_ADDR_LEVEL, 32'h7);
    rdc("level_readonly", WKIN_ADDR_LEVEL, 32'h0);
    xfer(1'b0, 8'h2c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, WKIN_ADDR_BIAS, {26'h0, {3{c[1:0]}}});
      rdc("bias_reg", WKIN_ADDR_BIAS, {26'h0, {3{c[1:0]}}});
      chk("bias_out", {26'h0, {3{c[1] & ~c[0]}}, {3{c[0]}}}, {26'h0, bias});
    end
    $display("test bias done");
    xfer(1'b1, WKIN_ADDR_WAKE_ENABLE, 32'h3);
    xfer(1'b1, WKIN_ADDR_SOURCE_MASK, 32'h7);
    xfer(1'b1, WKIN_ADDR_ALT_ENABLE, 32'h3);
    xfer(1'b1, WKIN_ADDR_ALT_MASK, 32'h3);
    xfer(1'b1, WKIN_ADDR_FILTER, 32'h4);
    pinset(5'h04);
    cyc(400);
    pinset(5'h00);
    cyc(900);
    chk("glitch_irq", 32'h0, {31'h0, irq});
    pinset(5'h1d);
    cyc(790);
    chk("early_irq", 32'h0, {31'h0, irq});
    cyc(20);
    chk("rise_irq", 32'h1, {31'h0, irq});
    rdc("source", WKIN_ADDR_SOURCE, 32'h1);
    rdc("alt_status", WKIN_ADDR_ALT_STATUS, 32'h1);
    rdc("level", WKIN_ADDR_LEVEL, 32'h5);
    chk("auto_bias", 32'h2a, {26'h0, bias});
    cyc(2300);
    rdc("long_early", WKIN_ADDR_SOURCE, 32'h1);
    cyc(100);
    rdc("long_done", WKIN_ADDR_SOURCE, 32'h3);
    xfer(1'b1, WKIN_ADDR_SOURCE_MASK, 32'h0);
    xfer(1'b1, WKIN_ADDR_ALT_MASK, 32'h0);
    cyc(3);
    chk("masked_irq", 32'h0, {31'h0, irq});
    xfer(1'b1, WKIN_ADDR_SOURCE_MASK, 32'h7);
    cyc(3);
    chk("unmasked_irq", 32'h1, {31'h0, irq});
    xfer(1'b1, WKIN_ADDR_SOURCE, 32'h7);
    xfer(1'b1, WKIN_ADDR_ALT_STATUS, 32'h3);
    cyc(3);
    chk("cleared_irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    mode <= WKIN_MODE_STOP;
    pinset(5'h19);
    cyc(810);
    chk("fall_irq", 32'h1, {31'h0, irq});
    chk("stop_no_wake", 32'h0, {31'h0, wake_req});
    xfer(1'b1, WKIN_ADDR_SOURCE, 32'h7);
    $display("test static done");
    @(posedge clk);
    mode <= WKIN_MODE_SLEEP;
    pinset(5'h1d);
    cyc(810);
    chk("sleep_wake", 32'h1, {31'h0, wake_req});
    @(posedge clk);
    mode <= WKIN_MODE_NORMAL;
    cyc(3);
    chk("normal_wake", 32'h0, {31'h0, wake_req});
    xfer(1'b1, WKIN_ADDR_SOURCE, 32'h7);
    $display("test sleep done");
    xfer(1'b1, WKIN_ADDR_TIMER_B, 32'hfa);
    xfer(1'b1, WKIN_ADDR_FILTER, 32'h38);
    xfer(1'b1, WKIN_ADDR_WAKE_ENABLE, 32'h7);
    @(posedge clk);
    cyc_supply <= 1'b1;
    cyc(3200);
    xfer(1'b1, WKIN_ADDR_SOURCE, 32'h7);
    wait_on(1'b1);
    wait_on(1'b0);
    pinset(5'h05);
    cyc(20);
    chk("off_time_irq", 32'h0, {31'h0, irq});
    xfer(1'b0, WKIN_ADDR_LEVEL, 32'h0);
    chk("sampled_level", 32'h4, rd & 32'h4);
    chk("timer_a_off", 32'h0, {31'h0, timer_on[0]});
    @(posedge clk);
    mode <= WKIN_MODE_FAILSAFE;
    cyc(470);
    chk("off_window", 32'h0, {31'h0, timer_on[1]});
    cyc(20);
    chk("on_window", 32'h1, {31'h0, timer_on[1]});
    cyc(1110);
    chk("failsafe_wake", 32'h1, {31'h0, wake_req});
    @(posedge clk);
    mode <= WKIN_MODE_NORMAL;
    rdc("cyclic_source", WKIN_ADDR_SOURCE, 32'h4);
    xfer(1'b0, WKIN_ADDR_LEVEL, 32'h0);
    chk("new_sample", 32'h0, rd & 32'h4);
    $display("test cyclic done");
    finish_test();
  end
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
endmodule : tb_wake_input_detection
`default_nettype wire
